// [include/cpu_stack_pkg.sv]
// shared constants and types for the cpu register and stack core
package cpu_stack_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_ACCUMULATOR  = 8'h00;
  localparam logic [7:0] OFF_INDEX_X      = 8'h04;
  localparam logic [7:0] OFF_INDEX_Y      = 8'h08;
  localparam logic [7:0] OFF_STACK_PTR    = 8'h0c;
  localparam logic [7:0] OFF_PROG_COUNTER = 8'h10;
  localparam logic [7:0] OFF_BASE_ADDRESS = 8'h14;
  localparam logic [7:0] OFF_COMMAND      = 8'h18;
  localparam logic [7:0] OFF_INT_STATUS   = 8'h1c;
  localparam logic [7:0] OFF_INT_CLEAR    = 8'h20;
  localparam logic [7:0] OFF_INT_ENABLE   = 8'h24;
  localparam logic [7:0] OFF_MODE_STATUS  = 8'h28;

  // command register fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_IDX_BIT   = 3;
  localparam int CMD_DATA_LSB  = 8;

  // interrupt status bit positions
  localparam int INT_W         = 7;
  localparam int INT_NMI       = 0;
  localparam int INT_EDGE_LSB  = 1;
  localparam int INT_DONE      = 5;
  localparam int INT_RANGE     = 6;

  // synchronised pin vector layout
  localparam int PIN_W         = 8;
  localparam int PIN_INIT      = 0;
  localparam int PIN_XIN       = 1;
  localparam int PIN_XOUT_TIED = 2;
  localparam int PIN_NMI       = 3;
  localparam int PIN_EDGE_LSB  = 4;
  localparam logic [7:0] PIN_IDLE = 8'hc9;

  // reset values and counts
  localparam logic [3:0]  INIT_HOLD_TICKS = 4'h8;
  localparam logic [5:0]  STACK_PAGE_HI   = 6'h00;
  localparam logic [7:0]  STACK_LOW_LIMIT = 8'h40;
  localparam logic [INT_W-1:0] INT_RESET  = 7'h00;
  localparam logic [13:0] BASE_RESET      = 14'h0000;

  typedef enum logic [2:0] {
    op_push      = 3'b000,
    op_pull      = 3'b001,
    op_call      = 3'b010,
    op_return    = 3'b011,
    op_break     = 3'b100,
    op_nmi       = 3'b101,
    op_load_idx  = 3'b110,
    op_store_idx = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01,
    st_data = 2'b10
  } bus_state_t;

endpackage

// [core/cpu_register_stack_core.sv]
// register set, stack sequencer, clock divider and interrupt edges of the cpu core
`timescale 1ns/1ps
module cpu_register_stack_core
  import cpu_stack_pkg::*;
#(
  parameter logic [15:0] RESET_VECTOR = 16'h3ffa,
  parameter logic [15:0] NMI_VECTOR   = 16'h3ff7,
  parameter logic [15:0] BREAK_VECTOR = 16'h3ffd
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        init_request_n,
  input  wire logic        crystal_in,
  input  wire logic        crystal_out_tied,
  input  wire logic        nmi_n,
  input  wire logic [3:0]  edge_in,
  output logic             phi2,
  output logic             irq,
  output logic [3:0]       addr_low,
  output logic [1:0]       addr_high,
  output logic             read_write,
  output logic             ems,
  input  wire logic [7:0]  shared_addr_data_in,
  output logic [7:0]       shared_addr_data_out,
  output logic             shared_addr_data_oe_n
);

  logic [7:0]       accumulator;
  logic [7:0]       index_x;
  logic [7:0]       index_y;
  logic [7:0]       stack_pointer;
  logic [15:0]      program_counter;
  logic [13:0]      base_address;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_enable;

  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_prev;
  logic [PIN_W-1:0] next_lvl;

  logic [3:0]  init_count;
  logic        nmi_pending;
  logic        busy;
  logic        step;
  logic        idx_sel;
  logic [7:0]  push_data;
  op_t         op;
  bus_state_t  state;

  // three-stage pin synchroniser, a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1    <= PIN_IDLE;
      sync2    <= PIN_IDLE;
      sync3    <= PIN_IDLE;
      pin_lvl  <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      sync1    <= {edge_in, nmi_n, crystal_out_tied, crystal_in, init_request_n};
      sync2    <= sync1;
      sync3    <= sync2;
      pin_lvl  <= next_lvl;
      pin_prev <= pin_lvl;
    end
  end

  // holding the old level on disagreement rejects one-cycle glitches
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_filter
      assign next_lvl[g] = (sync2[g] == sync3[g]) ? sync2[g] : pin_lvl[g];
    end
  endgenerate

  // clock mode and internal tick
  // tied mode follows the filtered input, so phi2 lags the pin by a few pclk
  wire div_by_one = pin_lvl[PIN_XOUT_TIED];
  wire xin_rise   = pin_lvl[PIN_XIN] & ~pin_prev[PIN_XIN];
  wire next_phi2  = div_by_one ? pin_lvl[PIN_XIN] : (xin_rise ? ~phi2 : phi2);
  wire tick       = next_phi2 & ~phi2;

  // edge events
  wire       nmi_fall = ~pin_lvl[PIN_NMI] & pin_prev[PIN_NMI];
  wire [3:0] edge_now  = pin_lvl[PIN_EDGE_LSB +: 4];
  wire [3:0] edge_last = pin_prev[PIN_EDGE_LSB +: 4];
  wire [3:0] edge_evt  = {edge_last[3:2] & ~edge_now[3:2],
                          edge_now[1:0] & ~edge_last[1:0]};

  // init pin honoured only after a sustained low level
  wire init_active = (init_count == INIT_HOLD_TICKS);
  wire [3:0] next_init_count = pin_lvl[PIN_INIT] ? 4'h0 :
                               (tick & ~init_active) ? init_count + 4'h1 : init_count;

  // apb decode
  wire sel_acc   = (paddr == OFF_ACCUMULATOR);
  wire sel_x     = (paddr == OFF_INDEX_X);
  wire sel_y     = (paddr == OFF_INDEX_Y);
  wire sel_sp    = (paddr == OFF_STACK_PTR);
  wire sel_pc    = (paddr == OFF_PROG_COUNTER);
  wire sel_base  = (paddr == OFF_BASE_ADDRESS);
  wire sel_cmd   = (paddr == OFF_COMMAND);
  wire sel_stat  = (paddr == OFF_INT_STATUS);
  wire sel_clr   = (paddr == OFF_INT_CLEAR);
  wire sel_en    = (paddr == OFF_INT_ENABLE);
  wire sel_mode  = (paddr == OFF_MODE_STATUS);
  wire sel_core  = sel_acc | sel_x | sel_y | sel_sp | sel_pc | sel_base | sel_cmd;
  wire mapped    = sel_core | sel_stat | sel_clr | sel_en | sel_mode;
  wire setup     = psel & ~penable;
  // core registers belong to the sequencer while it runs
  // a refused write still ends with pready, pslverr alone reports it
  wire refuse    = ~mapped | (pwrite & sel_core & (busy | nmi_pending));
  wire wr_ok     = psel & penable & pready & pwrite & ~pslverr;

  wire [31:0] read_word =
    sel_acc  ? {24'h000000, accumulator} :
    sel_x    ? {24'h000000, index_x} :
    sel_y    ? {24'h000000, index_y} :
    sel_sp   ? {24'h000000, stack_pointer} :
    sel_pc   ? {16'h0000, program_counter} :
    sel_base ? {18'h00000, base_address} :
    sel_cmd  ? {24'h000000, busy, step, state, idx_sel, op} :
    sel_stat ? {25'h0000000, int_status} :
    sel_en   ? {25'h0000000, int_enable} :
    sel_mode ? {30'h00000000, init_active, div_by_one} :
    32'h00000000;

  // sequencer decode
  wire cmd_start = wr_ok & sel_cmd;
  wire nmi_start = ~busy & nmi_pending & ~init_active;
  wire is_pull   = (op == op_pull) | (op == op_return);
  wire is_load   = (op == op_load_idx);
  wire is_stack  = ~is_load & (op != op_store_idx);
  wire two_byte  = (op == op_call) | (op == op_return) | (op == op_break) | (op == op_nmi);
  wire is_read   = is_pull | is_load;
  wire last_step = ~two_byte | step;

  // no carry out of the low byte, the stack never leaves its page
  wire [7:0] sp_up     = stack_pointer + 8'h01;
  wire [7:0] sp_down   = stack_pointer - 8'h01;
  wire [7:0] sp_access = is_pull ? sp_up : stack_pointer;
  wire [7:0] index_val = idx_sel ? index_y : index_x;
  wire [13:0] eff_addr = base_address + {6'h00, index_val};
  wire [13:0] acc_addr = is_stack ? {STACK_PAGE_HI, sp_access} : eff_addr;

  wire [7:0] pc_byte = step ? program_counter[7:0] : program_counter[15:8];
  wire [7:0] wdata   = (op == op_push)      ? push_data :
                       (op == op_store_idx) ? accumulator : pc_byte;
  wire [15:0] jump_target = (op == op_nmi)   ? NMI_VECTOR :
                            (op == op_break) ? BREAK_VECTOR : {2'b00, base_address};

  // accesses start on a tick so every bus phase lasts one internal cycle
  wire issue    = (state == st_idle) & busy & tick & ~init_active;
  wire finish   = (state == st_data) & tick;
  wire op_done  = finish & last_step;
  // an access below the stack floor is only flagged, it still runs
  wire range_ev = issue & is_stack & (sp_access < STACK_LOW_LIMIT);

  wire [INT_W-1:0] int_events = {range_ev, op_done, edge_evt, nmi_fall};
  wire [INT_W-1:0] int_clear  = (wr_ok & sel_clr) ? pwdata[INT_W-1:0] : INT_RESET;
  // set wins over a clear in the same cycle
  wire [INT_W-1:0] next_status = (int_status & ~int_clear) | int_events;

  // apb slave, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & refuse;
      if (setup) begin
        prdata <= read_word;
      end
    end
  end

  // clock output and init counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phi2       <= 1'b0;
      init_count <= 4'h0;
    end else begin
      phi2       <= next_phi2;
      init_count <= next_init_count;
    end
  end

  // interrupt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status  <= INT_RESET;
      int_enable  <= INT_RESET;
      irq         <= 1'b0;
      nmi_pending <= 1'b0;
    end else begin
      int_status  <= next_status;
      irq         <= |(next_status & int_enable);
      nmi_pending <= nmi_fall | (nmi_pending & ~nmi_start);
      if (wr_ok & sel_en) begin
        int_enable <= pwdata[INT_W-1:0];
      end
    end
  end

  // command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      step      <= 1'b0;
      op        <= op_push;
      idx_sel   <= 1'b0;
      push_data <= 8'h00;
      state     <= st_idle;
    end else if (init_active) begin
      busy  <= 1'b0;
      step  <= 1'b0;
      state <= st_idle;
    end else begin
      if (cmd_start) begin
        busy      <= 1'b1;
        step      <= 1'b0;
        op        <= op_t'(pwdata[CMD_OP_LSB +: 3]);
        idx_sel   <= pwdata[CMD_IDX_BIT];
        push_data <= pwdata[CMD_DATA_LSB +: 8];
      end else if (nmi_start) begin
        busy <= 1'b1;
        step <= 1'b0;
        op   <= op_nmi;
      end
      case (state)
        st_idle: begin
          if (issue) begin
            state <= st_addr;
          end
        end
        st_addr: begin
          if (tick) begin
            state <= st_data;
          end
        end
        st_data: begin
          if (finish) begin
            state <= st_idle;
            step  <= 1'b1;
            if (last_step) begin
              busy <= 1'b0;
              step <= 1'b0;
            end
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // stack pointer has no reset value, software must load it
  always_ff @(posedge pclk) begin
    if (wr_ok & sel_sp) begin
      stack_pointer <= pwdata[7:0];
    end else if (issue & is_pull) begin
      stack_pointer <= sp_up;
    end else if (finish & is_stack & ~is_pull) begin
      stack_pointer <= sp_down;
    end
  end

  // data registers, software writes land even while init holds the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator <= 8'h00;
    end else if (wr_ok & sel_acc) begin
      accumulator <= pwdata[7:0];
    end else if (finish & (op == op_pull | is_load)) begin
      // read pins taken unsynchronised, the memory shares pclk
      accumulator <= shared_addr_data_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_x      <= 8'h00;
      index_y      <= 8'h00;
      base_address <= BASE_RESET;
    end else begin
      if (wr_ok & sel_x) begin
        index_x <= pwdata[7:0];
      end
      if (wr_ok & sel_y) begin
        index_y <= pwdata[7:0];
      end
      if (wr_ok & sel_base) begin
        base_address <= pwdata[13:0];
      end
    end
  end

  // program counter held at the reset vector while init is honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= RESET_VECTOR;
    end else if (init_active) begin
      program_counter <= RESET_VECTOR;
    end else if (wr_ok & sel_pc) begin
      program_counter <= pwdata[15:0];
    end else if (finish & (op == op_return)) begin
      // return restores the counter as pulled, with no increment
      if (step) begin
        program_counter[15:8] <= shared_addr_data_in;
      end else begin
        program_counter[7:0] <= shared_addr_data_in;
      end
    end else if (op_done & two_byte & ~is_pull) begin
      program_counter <= jump_target;
    end
  end

  // multiplexed external bus: address phase, then data phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low              <= 4'h0;
      addr_high             <= 2'b00;
      read_write            <= 1'b1;
      ems                   <= 1'b0;
      shared_addr_data_out  <= 8'h00;
      shared_addr_data_oe_n <= 1'b1;
    end else if (init_active | finish) begin
      ems                   <= 1'b0;
      read_write            <= 1'b1;
      shared_addr_data_oe_n <= 1'b1;
    end else if (issue) begin
      addr_low              <= acc_addr[3:0];
      addr_high             <= acc_addr[13:12];
      shared_addr_data_out  <= acc_addr[11:4];
      shared_addr_data_oe_n <= 1'b0;
      read_write            <= is_read;
      ems                   <= 1'b1;
    end else if ((state == st_addr) & tick) begin
      shared_addr_data_out  <= wdata;
      // release the shared pins so memory can drive read data
      shared_addr_data_oe_n <= is_read;
    end
  end

endmodule

// [dv/cpu_ext_memory.sv]
// external program memory on the multiplexed address and data pins
`timescale 1ns/1ps
module cpu_ext_memory (
  input  wire logic       pclk,
  input  wire logic       ems,
  input  wire logic       read_write,
  input  wire logic       shared_addr_data_oe_n,
  input  wire logic [3:0] addr_low,
  input  wire logic [1:0] addr_high,
  input  wire logic [7:0] shared_addr_data_out,
  output logic      [7:0] shared_addr_data_in
);
  logic [7:0]  mem [0:16383];
  logic [13:0] addr;
  logic        ems_q = 1'b0;
  logic [7:0]  last = 8'h00;
  // released pins show a changing pattern, never a held value
  assign shared_addr_data_in = (ems && read_write && shared_addr_data_oe_n) ? mem[addr] : ~last;
  always @(posedge pclk) begin
    ems_q <= ems;
    last <= shared_addr_data_in;
    if (ems && !ems_q) begin
      addr <= {addr_high, shared_addr_data_out, addr_low};
    end else if (ems && !read_write && !shared_addr_data_oe_n) begin
      mem[addr] <= shared_addr_data_out;
    end
  end
endmodule

// [dv/cpu_register_stack_core_sva.sv]
// concurrent checks on the ports of the cpu register and stack core
`timescale 1ns/1ps
module cpu_register_stack_core_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       init_request_n,
  input wire logic       crystal_out_tied,
  input wire logic       phi2,
  input wire logic       irq,
  input wire logic [3:0] addr_low,
  input wire logic [1:0] addr_high,
  input wire logic       read_write,
  input wire logic       ems,
  input wire logic       shared_addr_data_oe_n
);
  logic [7:0] init_low;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) init_low <= 8'h00;
    else if (init_request_n) init_low <= 8'h00;
    else if (init_low != 8'hff) init_low <= init_low + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  addr_phase_drive_a: assert property ($rose(ems) |-> !shared_addr_data_oe_n)
    else $error("address phase not driven");
  write_drive_a: assert property (ems && !read_write |-> !shared_addr_data_oe_n)
    else $error("write data released early");
  access_pins_a: assert property (ems && $past(ems) |-> $stable({addr_low, addr_high, read_write}))
    else $error("address moved within access");
  access_bounded_a: assert property ($rose(ems) |-> ##[1:100] !ems)
    else $error("access never ends");
  init_idles_bus_a: assert property (init_low >= 8'h64 |-> !ems)
    else $error("bus active under init");
  phi2_halved_a: assert property (!crystal_out_tied && !$past(crystal_out_tied, 8) && $changed(phi2)
    |=> $stable(phi2))
    else $error("phi2 toggles too fast");
  cover property (ems && !read_write);
  cover property (ems && read_write && shared_addr_data_oe_n);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule
bind cpu_register_stack_core cpu_register_stack_core_sva u_sva (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .init_request_n, .crystal_out_tied,
  .phi2, .irq, .addr_low, .addr_high, .read_write, .ems, .shared_addr_data_oe_n
);

// [dv/cpu_register_stack_core_tb.sv]
// self-checking bench for the cpu register and stack core
`timescale 1ns/1ps
module cpu_register_stack_core_tb
  import cpu_stack_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        init_request_n = 1'b0, crystal_in = 1'b0, crystal_out_tied = 1'b0, nmi_n = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  edge_in = 4'hc, xcnt = 4'h0, addr_low;
  logic        pready, pslverr, phi2, irq, read_write, ems, shared_addr_data_oe_n, lerr;
  logic [1:0]  addr_high;
  logic [7:0]  shared_addr_data_in, shared_addr_data_out;
  int          err_total = 0, num_checks = 0;
  cpu_register_stack_core DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .init_request_n, .crystal_in, .crystal_out_tied, .nmi_n, .edge_in, .phi2, .irq, .addr_low,
    .addr_high, .read_write, .ems, .shared_addr_data_in, .shared_addr_data_out, .shared_addr_data_oe_n
  );
  cpu_ext_memory MEM (
    .pclk, .ems, .read_write, .shared_addr_data_oe_n, .addr_low, .addr_high,
    .shared_addr_data_out, .shared_addr_data_in
  );
  always #2.5 pclk = ~pclk;
  // reference clock at a quarter of pclk so the synchroniser sees every edge
  always @(posedge pclk) begin
    xcnt <= xcnt + 4'h1;
    crystal_in <= xcnt[1];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdv, e, m);
  endtask
  task automatic waitd(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      n++;
    end while (rdv[INT_DONE] !== 1'b1 && n < 100);
    s = rdv;
    chk(s[INT_DONE], 32'h1, "command done");
    apb(1'b1, OFF_INT_CLEAR, 32'h7f);
  endtask
  task automatic run(input op_t o, input logic y, input logic [7:0] d);
    logic [31:0] s;
    apb(1'b1, OFF_COMMAND, {16'h0, d, 4'h0, y, o});
    waitd(s);
  endtask
  task automatic t_regs;
    rc(OFF_PROG_COUNTER, 32'h3ffa, "pc reset");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'(i * 4), 32'h5a + i);
      rc(8'(i * 4), 32'h5a + i, "register readback");
    end
    rc(8'h40, 32'h0, "unmapped read");
    chk(lerr, 32'h1, "unmapped error");
    $display("register test done");
  endtask
  task automatic t_clock;
    int n;
    int e;
    logic q;
    for (int m = 0; m < 2; m++) begin
      crystal_out_tied <= m[0];
      repeat (16) @(posedge pclk);
      n = 0;
      q = phi2;
      repeat (64) begin
        @(posedge pclk);
        if (phi2 === 1'b1 && q === 1'b0) n++;
        q = phi2;
      end
      e = m ? 16 : 8;
      chk(32'(n > e - 2 && n < e + 2), 32'h1, "phi2 rate");
      rc(OFF_MODE_STATUS, 32'(m), "divider mode");
    end
    $display("clock test done");
  endtask
  task automatic t_stack;
    logic [31:0] s;
    apb(1'b1, OFF_STACK_PTR, 32'h0);
    apb(1'b1, OFF_COMMAND, {16'h0, 8'ha5, 8'h00});
    waitd(s);
    chk(s[INT_RANGE], 32'h1, "below stack floor");
    chk(MEM.mem[0], 32'ha5, "push at pointer");
    rc(OFF_STACK_PTR, 32'hff, "push wraps");
    apb(1'b1, OFF_COMMAND, {16'h0, 8'h3c, 8'h00});
    apb(1'b1, OFF_ACCUMULATOR, 32'h11);
    chk(lerr, 32'h1, "write while busy");
    waitd(s);
    chk(MEM.mem[255], 32'h3c, "second push");
    chk(s[INT_RANGE], 32'h0, "inside stack page");
    run(op_pull, 1'b0, 8'h00);
    rc(OFF_ACCUMULATOR, 32'h3c, "pull data");
    run(op_pull, 1'b0, 8'h00);
    rc(OFF_ACCUMULATOR, 32'ha5, "pull wraps");
    rc(OFF_STACK_PTR, 32'h00, "pointer after pulls");
    $display("stack test done");
  endtask
  task automatic t_call;
    apb(1'b1, OFF_STACK_PTR, 32'hff);
    apb(1'b1, OFF_PROG_COUNTER, 32'h2468);
    apb(1'b1, OFF_BASE_ADDRESS, 32'h1234);
    run(op_call, 1'b0, 8'h00);
    rc(OFF_PROG_COUNTER, 32'h1234, "call target");
    chk({MEM.mem[255], MEM.mem[254]}, 32'h2468, "saved return");
    run(op_return, 1'b0, 8'h00);
    rc(OFF_PROG_COUNTER, 32'h2468, "return");
    run(op_break, 1'b0, 8'h00);
    rc(OFF_PROG_COUNTER, 32'h3ffd, "break vector");
    rc(OFF_STACK_PTR, 32'hfd, "break push");
    $display("call test done");
  endtask
  task automatic t_nmi;
    logic [31:0] s;
    apb(1'b1, OFF_STACK_PTR, 32'hff);
    nmi_n <= 1'b0;
    waitd(s);
    chk(s[INT_NMI], 32'h1, "nmi edge");
    rc(OFF_PROG_COUNTER, 32'h3ff7, "nmi vector");
    rc(OFF_STACK_PTR, 32'hfd, "nmi stack");
    repeat (40) @(posedge pclk);
    rc(OFF_INT_STATUS, 32'h0, "held low");
    nmi_n <= 1'b1;
    $display("nmi test done");
  endtask
  task automatic t_edges;
    edge_in <= 4'h3;
    repeat (8) @(posedge pclk);
    rc(OFF_INT_STATUS, 32'h1e, "edge events");
    chk(irq, 32'h0, "masked");
    apb(1'b1, OFF_INT_ENABLE, 32'h04);
    @(posedge pclk);
    chk(irq, 32'h1, "enabled");
    apb(1'b1, OFF_INT_CLEAR, 32'h04);
    @(posedge pclk);
    chk(irq, 32'h0, "cleared");
    apb(1'b1, OFF_INT_CLEAR, 32'h7f);
    edge_in <= 4'hc;
    repeat (8) @(posedge pclk);
    rc(OFF_INT_STATUS, 32'h0, "wrong direction");
    $display("edge test done");
  endtask
  task automatic t_index;
    apb(1'b1, OFF_INDEX_X, 32'h03);
    apb(1'b1, OFF_INDEX_Y, 32'h05);
    apb(1'b1, OFF_BASE_ADDRESS, 32'h0100);
    apb(1'b1, OFF_ACCUMULATOR, 32'h5a);
    run(op_store_idx, 1'b0, 8'h00);
    chk(MEM.mem[14'h0103], 32'h5a, "indexed store");
    MEM.mem[14'h0105] = 8'hc3;
    run(op_load_idx, 1'b1, 8'h00);
    rc(OFF_ACCUMULATOR, 32'hc3, "indexed load");
    $display("index test done");
  endtask
  task automatic t_init;
    init_request_n <= 1'b0;
    repeat (120) @(posedge pclk);
    rc(OFF_MODE_STATUS, 32'h3, "init active");
    rc(OFF_PROG_COUNTER, 32'h3ffa, "vector held");
    init_request_n <= 1'b1;
    repeat (20) @(posedge pclk);
    rc(OFF_MODE_STATUS, 32'h1, "init released");
    $display("init test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // init stays low well past eight internal cycles before release
    repeat (100) @(posedge pclk);
    rc(OFF_MODE_STATUS, 32'h2, "init at power up");
    init_request_n <= 1'b1;
    repeat (10) @(posedge pclk);
    t_regs();
    t_clock();
    t_stack();
    t_call();
    t_nmi();
    t_edges();
    t_index();
    t_init();
    summarize();
  end
  initial begin
    #100000;
    err_total++;
    $display("unexpected at %0t: watchdog", $time);
    summarize();
  end
endmodule
